// File: verif/core_model.sv
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk,        // cpu clock
  input  wire logic       resetn,     // sync reset, low
  input  wire logic       branch_req, // branch offered
  input  wire logic [1:0] delay,      // wait before ack, 3 = stall
  output logic            branch_ack  // branch taken
);
  logic [1:0] wait_cnt;
  // ack lasts one edge so a branch is never taken twice
  always_ff @(posedge clk) begin
    if (!resetn || branch_ack || !branch_req) begin
      branch_ack <= 1'b0;
      wait_cnt   <= 2'h0;
    end else if (delay != 2'h3 && wait_cnt >= delay) begin
      branch_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 0, resetn = 0, ce = 1, sw_trap = 0, svc_return = 0;
  logic [6:0] sw_trap_num = 0;
  logic [15:0] src_set = 0, src_enable = 0, event_done = 0, flag_clear = 0;
  logic [63:0] src_prio = 0;
  logic [1:0] delay = 0;
  logic [3:0] l;
  logic [15:0] f;
  trap_pkg::svc_t k;
  trap_pkg::trap_src_t trap_in = 0;
  logic branch_ack, branch_req;
  trap_pkg::branch_t branch;
  logic [15:0] trap_flag_register, src_request;
  logic [3:0] cpu_level;
  trap_pkg::svc_t running;
  int failures = 0, check_count = 0, i, n, m, p;
  always #5 clk = ~clk;
  trap_and_vector_logic dut (.clk, .resetn, .ce, .trap_in, .src_set,
    .src_enable, .src_prio, .event_done, .sw_trap, .sw_trap_num,
    .flag_clear, .svc_return, .branch_ack, .branch_req, .branch,
    .trap_flag_register, .src_request, .cpu_level, .running);
  core_model core (.clk, .resetn, .branch_req, .delay, .branch_ack);
  task automatic tick(int c = 1);
    repeat (c) @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // vector worked out as four times the number
  task automatic chk_br(logic [6:0] num, trap_pkg::svc_t kind);
    chk({branch_req, branch}, {1'b1, num, 15'h0, num, 2'b00, kind});
  endtask
  task automatic wait_run(trap_pkg::svc_t kind);
    int w;
    // a service counts as entered once its branch is no longer pending
    for (w = 0; w < 9 && (running !== kind || branch_req !== 1'b0); w++) begin
      tick();
    end
    if (w == 9) begin
      failures++;
      finish_test();
    end
    chk(running, kind);
  endtask
  task automatic ret();
    svc_return = 1;
    flag_clear = 16'hffff;
    tick();
    svc_return = 0;
    flag_clear = 0;
  endtask
  task automatic raise(int s);
    src_set[s] = 1;
    tick();
    src_set = 0;
  endtask
  task automatic drain();
    delay = 0;
    repeat (4) begin
      tick(4);
      ret();
    end
  endtask
  initial begin
    void'($urandom(32'h9a98f83b));
    tick(6);
    resetn = 1;
    tick();
    for (i = 0; i < 8; i++) begin
      trap_in = 8'h80 >> i;
      n = i < 3 ? 2 + 2 * i : 10;
      k = trap_pkg::svc_t'(i < 3 ? 3 : 2);
      f = i < 3 ? 16'h8000 >> i : i == 7 ? 16'h80 : 16'h1 << (i - 3);
      tick();
      trap_in = 0;
      chk_br(7'(n), k);
      chk(trap_flag_register, f);
      wait_run(k);
      ret();
    end
    // class a breaks into class b; class b waits out class a
    trap_in.bad_opcode = 1;
    tick();
    trap_in = 0;
    wait_run(trap_pkg::SVC_TRAPB);
    trap_in.nmi = 1;
    tick();
    trap_in = 0;
    chk_br(7'h02, trap_pkg::SVC_TRAPA);
    wait_run(trap_pkg::SVC_TRAPA);
    trap_in.guarded_instr = 1;
    tick();
    trap_in = 0;
    chk({branch_req, trap_flag_register}, 17'h08003);
    ret();
    chk_br(7'h0a, trap_pkg::SVC_TRAPB);
    wait_run(trap_pkg::SVC_TRAPB);
    ret();
    src_enable = 16'hffff;
    src_prio = '1;
    delay = 3;
    raise(0);
    tick();
    chk_br(7'h32, trap_pkg::SVC_INT);
    trap_in.stack_over = 1;
    tick();
    trap_in = 0;
    chk_br(7'h04, trap_pkg::SVC_TRAPA);
    delay = 0;
    wait_run(trap_pkg::SVC_TRAPA);
    raise(1);
    tick(3);
    chk({branch_req, src_request[1:0]}, 3'b011);
    drain();
    repeat (6) begin
      n = $urandom_range(15);
      m = (n + 1) % 16;
      p = (n + 2) % 16;
      l = 4'(1 + $urandom_range(13));
      src_prio = {$urandom, $urandom};
      src_prio[4*n +: 4] = l;
      src_prio[4*m +: 4] = l;
      src_prio[4*p +: 4] = l + 4'h1;
      raise(n);
      chk(src_request[n], 1);
      tick();
      chk_br(trap_pkg::SRC_TRAPNUM[n], trap_pkg::SVC_INT);
      wait_run(trap_pkg::SVC_INT);
      chk(cpu_level, l);
      raise(m);
      tick(3);
      chk({branch_req, src_request[m]}, 2'b01);
      raise(p);
      tick();
      chk_br(trap_pkg::SRC_TRAPNUM[p], trap_pkg::SVC_INT);
      wait_run(trap_pkg::SVC_INT);
      chk(cpu_level, l + 4'h1);
      ret();
      tick();
      chk_br(trap_pkg::SRC_TRAPNUM[m], trap_pkg::SVC_INT);
      drain();
    end
    for (i = 0; i < 4; i++) begin
      sw_trap_num = i == 0 ? 7'h7f : 7'($urandom_range(127));
      sw_trap = 1;
      tick();
      sw_trap = 0;
      chk_br(sw_trap_num, trap_pkg::SVC_INT);
      wait_run(trap_pkg::SVC_INT);
      chk(cpu_level, 4'h0);
      ret();
    end
    event_done[5] = 1;
    tick();
    event_done = 0;
    chk(src_request[5], 1);
    tick();
    chk_br(trap_pkg::SRC_TRAPNUM[5], trap_pkg::SVC_INT);
    drain();
    // reset in mid-run with a branch and a request pending
    delay = 3;
    trap_in.bad_opcode = 1;
    src_set[3] = 1;
    tick();
    trap_in = 0;
    src_set = 0;
    resetn = 0;
    tick();
    chk({branch_req, branch}, 34'h0);
    chk({trap_flag_register, src_request, cpu_level, running}, 38'h0);
    resetn = 1;
    delay = 0;
    // events offered while the clock enable is low are not taken
    ce = 0;
    trap_in.nmi = 1;
    src_set[2] = 1;
    tick();
    trap_in = 0;
    src_set = 0;
    ce = 1;
    tick();
    chk({branch_req, trap_flag_register, src_request}, 33'h0);
    finish_test();
  end
endmodule

// File: verif/trap_props.sv
`timescale 1ns/1ps
module trap_props (
  input wire logic                clk, resetn, ce, svc_return,
  input wire logic                branch_ack, branch_req,
  input wire trap_pkg::trap_src_t trap_in,
  input wire trap_pkg::branch_t   branch,
  input wire logic [15:0]         trap_flag_register,
  input wire logic [3:0]          cpu_level,
  input wire trap_pkg::svc_t      running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_vec;
    branch_req |-> branch.vector == {15'h0, branch.trap_number, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("vector not 4x number");
  property p_flag_over;
    ce && trap_in.stack_over |=> trap_flag_register[14];
  endproperty
  a_flag_over: assert property (p_flag_over) else $error("flag 14");
  property p_flag_opc;
    ce && trap_in.bad_opcode |=> trap_flag_register[0];
  endproperty
  a_flag_opc: assert property (p_flag_opc) else $error("flag 0");
  property p_classb;
    branch_req && branch.kind == trap_pkg::SVC_TRAPB |->
      branch.trap_number == 7'h0a;
  endproperty
  a_classb: assert property (p_classb) else $error("class b num");
  property p_hold;
    ce && branch_req && !branch_ack |=> branch_req;
  endproperty
  a_hold: assert property (p_hold) else $error("branch dropped");
  property p_ack;
    ce && branch_req && branch_ack && !svc_return |=>
      running == $past(branch.kind);
  endproperty
  a_ack: assert property (p_ack) else $error("running kind");
  property p_nmi;
    ce && trap_in.nmi && running != trap_pkg::SVC_TRAPA && !branch_ack
      |=> branch_req && branch.kind == trap_pkg::SVC_TRAPA;
  endproperty
  a_nmi: assert property (p_nmi) else $error("trap not taken");
  property p_noint;
    running inside {trap_pkg::SVC_TRAPA, trap_pkg::SVC_TRAPB} && branch_req
      |-> branch.kind != trap_pkg::SVC_INT;
  endproperty
  a_noint: assert property (p_noint) else $error("int in trap");
  property p_ret;
    ce && svc_return && !branch_ack |=>
      running == trap_pkg::SVC_NONE && cpu_level == 4'h0;
  endproperty
  a_ret: assert property (p_ret) else $error("return level");
endmodule
bind trap_and_vector_logic trap_props u_props (.clk, .resetn, .ce,
  .svc_return, .branch_ack, .branch_req, .trap_in, .branch,
  .trap_flag_register, .cpu_level, .running);

// File: verilog/src_arbiter.sv
`timescale 1ns/1ps
module src_arbiter (
  input  wire logic [15:0] pending,  // request and enable per source
  input  wire logic [63:0] prio,     // four bits of level per source
  output logic             found,    // some source is pending
  output logic [3:0]       level,    // winning level
  output logic [3:0]       index     // winning source
);
  // lowest index wins a tie of equal levels
  always_comb begin
    found = 1'b0;
    level = trap_pkg::PRIO_IDLE;
    index = 4'h0;
    for (int i = trap_pkg::SRC_COUNT - 1; i >= 0; i--) begin
      if (pending[i] && (!found || prio[i*4 +: 4] >= level)) begin
        found = 1'b1;
        level = prio[i*4 +: 4];
        index = 4'(i);
      end
    end
  end
endmodule

// File: verilog/trap_and_vector_logic.sv
`timescale 1ns/1ps
// How it works
// - each source: request, enable, vector, number
// - hardware trap branches, cannot be masked
// - hardware trap sets its flag bit
// - trap preempts unless same or higher class trap running
// - trap service blocks interrupts and events
// - five class b flags share one vector
// - software trap takes any number, current priority
// - sixteen programmable priority levels per source
// - only higher priority interrupts running service
// - event counter zero gives standard interrupt
module trap_and_vector_logic (
  input  wire logic                clk,          // cpu clock
  input  wire logic                resetn,       // sync reset, low
  input  wire logic                ce,           // clock enable
  input  wire trap_pkg::trap_src_t trap_in,      // detector pulses
  input  wire logic [15:0]         src_set,      // peripheral requests
  input  wire logic [15:0]         src_enable,   // per source enables
  input  wire logic [63:0]         src_prio,     // levels per source
  input  wire logic [15:0]         event_done,   // counter hit zero
  input  wire logic                sw_trap,      // trap instruction
  input  wire logic [6:0]          sw_trap_num,  // its trap number
  input  wire logic [15:0]         flag_clear,   // clear trap flags
  input  wire logic                svc_return,   // service finished
  input  wire logic                branch_ack,   // core took branch
  output logic                     branch_req,   // branch pending
  output trap_pkg::branch_t        branch,       // branch target
  output logic [15:0]              trap_flag_register, // trap flags
  output logic [15:0]              src_request,  // request flags
  output logic [3:0]               cpu_level,    // running priority
  output trap_pkg::svc_t           running       // service in force
);
  logic [15:0]       next_flags;
  logic [15:0]       next_req;
  logic              next_branch_req;
  trap_pkg::branch_t next_branch;
  logic [3:0]        next_level;
  trap_pkg::svc_t    next_running;
  logic              found;
  logic [3:0]        win_level;
  logic [3:0]        win_index;
  logic              class_a;
  logic              class_b;
  logic [6:0]        a_num;
  logic [2:0]        a_want;
  logic [2:0]        a_sel;
  logic [2:0]        a_pend;
  logic [2:0]        next_a_pend;
  logic              b_pend;
  logic              next_b_pend;
  logic              src_pend;
  logic              next_src_pend;
  logic [3:0]        src_idx;
  logic [3:0]        next_src_idx;
  logic [3:0]        src_level;
  logic [3:0]        next_src_level;
  logic              take_src;
  logic              restore_src;

  src_arbiter u_arb (
    .pending (src_request & src_enable),
    .prio    (src_prio),
    .found   (found),
    .level   (win_level),
    .index   (win_index)
  );

  function automatic logic [23:0] vec_of(input logic [6:0] n);
    vec_of = {15'h0000, n, 2'b00};
  endfunction

  always_comb begin
    // causes that could not branch yet are held, nmi first
    a_want  = a_pend | {trap_in.nmi, trap_in.stack_over,
                        trap_in.stack_under};
    class_a = |a_want;
    class_b = b_pend | trap_in.bad_opcode | trap_in.guarded_instr |
              trap_in.misaligned_operand | trap_in.misaligned_fetch |
              trap_in.bad_external_access;
    // nmi above stack overflow above underflow
    if (a_want[2]) begin
      a_num = trap_pkg::NMI_TRAPNUM;
      a_sel = 3'b100;
    end else if (a_want[1]) begin
      a_num = trap_pkg::STACK_OVER_FLAG_TRAPNUM;
      a_sel = 3'b010;
    end else begin
      a_num = trap_pkg::STACK_UNDER_FLAG_TRAPNUM;
      a_sel = 3'b001;
    end
  end

  always_comb begin
    next_flags      = trap_flag_register & ~flag_clear;
    next_flags[trap_pkg::BIT_NMI]         |= trap_in.nmi;
    next_flags[trap_pkg::BIT_STACK_OVER]  |= trap_in.stack_over;
    next_flags[trap_pkg::BIT_STACK_UNDER] |= trap_in.stack_under;
    next_flags[trap_pkg::BIT_BAD_OPCODE]  |= trap_in.bad_opcode;
    next_flags[trap_pkg::BIT_GUARDED]     |= trap_in.guarded_instr;
    next_flags[trap_pkg::BIT_MISAL_OPND]  |= trap_in.misaligned_operand;
    next_flags[trap_pkg::BIT_MISAL_FETCH] |= trap_in.misaligned_fetch;
    next_flags[trap_pkg::BIT_BAD_EXT]     |= trap_in.bad_external_access;
  end

  always_comb begin
    next_branch_req = branch_req;
    next_branch     = branch;
    next_level      = cpu_level;
    next_running    = running;
    // refused traps stay pending until allowed
    next_a_pend     = a_want;
    next_b_pend     = class_b;
    next_src_pend   = src_pend;
    next_src_idx    = src_idx;
    next_src_level  = src_level;
    take_src        = 1'b0;
    restore_src     = 1'b0;
    if (svc_return) begin
      next_running = trap_pkg::SVC_NONE;
      next_level   = trap_pkg::PRIO_IDLE;
    end
    if (branch_req && branch_ack) begin
      next_branch_req = 1'b0;
      next_running    = branch.kind;
      next_src_pend   = 1'b0;
      // source level applies once its service starts
      if (src_pend) begin
        next_level = src_level;
      end
    end
    // class a preempts all but class a
    if (class_a && next_running != trap_pkg::SVC_TRAPA &&
        !(next_branch_req && next_branch.kind == trap_pkg::SVC_TRAPA)) begin
      // a displaced class b branch is held again, a source request too
      if (next_branch_req && next_branch.kind == trap_pkg::SVC_TRAPB) begin
        next_b_pend = 1'b1;
      end
      restore_src             = next_branch_req && next_src_pend;
      next_src_pend           = 1'b0;
      next_branch_req         = 1'b1;
      next_branch.kind        = trap_pkg::SVC_TRAPA;
      next_branch.trap_number = a_num;
      next_branch.vector      = vec_of(a_num);
      // the other class a causes keep waiting
      next_a_pend             = a_want & ~a_sel;
    end else if (class_b && next_running != trap_pkg::SVC_TRAPA &&
                 next_running != trap_pkg::SVC_TRAPB &&
                 !(next_branch_req &&
                   next_branch.kind != trap_pkg::SVC_INT)) begin
      restore_src             = next_branch_req && next_src_pend;
      next_src_pend           = 1'b0;
      next_b_pend             = 1'b0;
      next_branch_req         = 1'b1;
      next_branch.kind        = trap_pkg::SVC_TRAPB;
      next_branch.trap_number = trap_pkg::CLASSB_TRAPNUM;
      next_branch.vector      = vec_of(trap_pkg::CLASSB_TRAPNUM);
    end else if (sw_trap && !next_branch_req) begin
      next_branch_req         = 1'b1;
      next_branch.kind        = trap_pkg::SVC_INT;
      next_branch.trap_number = sw_trap_num & trap_pkg::SW_TRAP_MAX;
      next_branch.vector      = vec_of(sw_trap_num & trap_pkg::SW_TRAP_MAX);
    end else if (found && !next_branch_req &&
                 next_running != trap_pkg::SVC_TRAPA &&
                 next_running != trap_pkg::SVC_TRAPB &&
                 (win_level > next_level ||
                  next_running == trap_pkg::SVC_NONE)) begin
      next_branch_req         = 1'b1;
      next_branch.kind        = trap_pkg::SVC_INT;
      next_branch.trap_number = trap_pkg::SRC_TRAPNUM[win_index];
      next_branch.vector      = vec_of(trap_pkg::SRC_TRAPNUM[win_index]);
      take_src                = 1'b1;
      next_src_pend           = 1'b1;
      next_src_idx            = win_index;
      next_src_level          = win_level;
    end
  end

  always_comb begin
    next_req = src_request;
    if (take_src) begin
      next_req[win_index] = 1'b0;
    end
    // a request whose branch a trap displaced is raised again
    if (restore_src) begin
      next_req[src_idx] = 1'b1;
    end
    next_req = next_req | src_set | event_done;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      trap_flag_register <= trap_pkg::FLAG_RESET;
    end else if (ce) begin
      trap_flag_register <= next_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_request <= trap_pkg::SRC_RESET;
    end else if (ce) begin
      src_request <= next_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      branch_req <= 1'b0;
      branch     <= '{trap_number: trap_pkg::RESET_TRAPNUM,
                      vector: 24'h000000,
                      kind: trap_pkg::SVC_NONE};
      cpu_level  <= trap_pkg::PRIO_IDLE;
      running    <= trap_pkg::SVC_NONE;
      a_pend     <= 3'h0;
      b_pend     <= 1'b0;
      src_pend   <= 1'b0;
      src_idx    <= 4'h0;
      src_level  <= trap_pkg::PRIO_IDLE;
    end else if (ce) begin
      branch_req <= next_branch_req;
      branch     <= next_branch;
      cpu_level  <= next_level;
      running    <= next_running;
      a_pend     <= next_a_pend;
      b_pend     <= next_b_pend;
      src_pend   <= next_src_pend;
      src_idx    <= next_src_idx;
      src_level  <= next_src_level;
    end
  end
endmodule

// File: verilog/trap_pkg.sv
package trap_pkg;

  localparam int SRC_COUNT   = 16;
  localparam int PRIO_W      = 4;
  localparam int TRAPNUM_W   = 7;
  localparam int VEC_W       = 24;

  // trap number to vector location: location is number times four
  localparam int VEC_SHIFT   = 2;

  localparam logic [6:0] RESET_TRAPNUM  = 7'h00;
  localparam logic [6:0] NMI_TRAPNUM    = 7'h02;
  localparam logic [6:0] STACK_OVER_FLAG_TRAPNUM  = 7'h04;
  localparam logic [6:0] STACK_UNDER_FLAG_TRAPNUM  = 7'h06;
  localparam logic [6:0] CLASSB_TRAPNUM = 7'h0a;
  localparam logic [6:0] SW_TRAP_MAX    = 7'h7f;

  // trap flag register bit positions
  localparam int FLAG_W          = 16;
  localparam int BIT_NMI         = 15;
  localparam int BIT_STACK_OVER  = 14;
  localparam int BIT_STACK_UNDER = 13;
  localparam int BIT_BAD_EXT     = 7;
  localparam int BIT_MISAL_FETCH = 3;
  localparam int BIT_MISAL_OPND  = 2;
  localparam int BIT_GUARDED     = 1;
  localparam int BIT_BAD_OPCODE  = 0;

  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] SRC_RESET  = 16'h0000;
  localparam logic [3:0]  PRIO_IDLE  = 4'h0;

  // peripheral source trap numbers; entry 0 is capture/compare channel 18
  localparam logic [6:0] SRC_TRAPNUM [SRC_COUNT] = '{
    7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37, 7'h38, 7'h39,
    7'h3a, 7'h3b, 7'h3c, 7'h44, 7'h45, 7'h46, 7'h20, 7'h21};

  typedef enum logic [1:0] {
    SVC_NONE  = 2'b00,
    SVC_INT   = 2'b01,
    SVC_TRAPB = 2'b10,
    SVC_TRAPA = 2'b11
  } svc_t;

  typedef struct packed {
    logic [6:0]  trap_number;
    logic [23:0] vector;
    svc_t        kind;
  } branch_t;

  typedef struct packed {
    logic nmi;
    logic stack_over;
    logic stack_under;
    logic bad_opcode;
    logic guarded_instr;
    logic misaligned_operand;
    logic misaligned_fetch;
    logic bad_external_access;
  } trap_src_t;

endpackage
